// ==== verilog/asc_core.sv ====
// Purpose: Autorange sensitivity controller for a 3-1/2 digit reading.
// Assumes: reading_valid pulses once per conversion with its magnitude count.
// Notes: Avalon-MM slave answers one cycle after a request.
// Behaviour
// - Overrange in auto steps to less sensitive
// - Blank three low digits while changing
// - Top range overvolt keeps reading and blinks
// - Top range wraps, beyond limit shows 17
// - Below 180 counts steps to more sensitive
// - Selector: five fixed ranges plus auto
// - Remote code maps to five ranges
// - Override low forces remote, open returns auto
// - Remote applies only at auto position
// - Four functions with 8/4/11 ranges
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module asc_core
  import asc_pkg::*;
#(
  parameter int BLINK_TICK = BLINK_CYCLES,
  parameter logic [1:0] SETTLE_READS = SETTLE_READS_RST
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Converter reading
  input wire logic reading_valid,
  input wire logic [11:0] reading_count,
  // Front panel and remote lines
  input wire logic [2:0] sens_selector,
  input wire logic [5:0] function_range_selector,
  input wire logic remote_override_line,
  input wire logic remote_code_weight4,
  input wire logic remote_code_weight2,
  input wire logic remote_code_weight1,
  // Display
  output logic [2:0] sens_range,
  output logic [10:0] disp_count,
  output logic low_digits_on,
  output logic overvolt,
  output logic range_changing,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq
);
  asc_sel_if sel ();
  asc_range_e range;
  asc_range_e next_range;
  asc_state_e state;
  asc_state_e next_state;
  logic [1:0] settle_left;
  logic hold;
  logic blink_tick;
  logic blink_phase;
  logic auto_active;
  logic over_full;
  logic under_thresh;
  logic hot_current;
  logic bad_range;
  logic hot_q;
  logic bad_q;
  logic overvolt_q;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_clr;
  logic bus_req;
  logic bus_take;
  asc_func_e func;
  logic [3:0] func_range;

  asc_sel_decode u_decode (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sens_selector(sens_selector),
    .remote_override_line(remote_override_line),
    .remote_code_weight4(remote_code_weight4),
    .remote_code_weight2(remote_code_weight2),
    .remote_code_weight1(remote_code_weight1),
    .sel(sel)
  );

  asc_tick #(
    .CYCLES(BLINK_TICK)
  ) u_blink (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(blink_tick)
  );

  assign func = asc_func_e'(function_range_selector[5:4]);
  assign func_range = function_range_selector[3:0];
  assign over_full = reading_count > CNT_FULL;
  assign under_thresh = reading_count < CNT_DOWN_THRESH;
  // Remote only counts while the selector stands at auto
  assign auto_active = sel.auto_sel && !sel.remote_active && !hold;

  // Range selection
  always_comb begin
    next_range = range;
    if (!sel.auto_sel) begin
      next_range = sel.manual_range;
    end else if (sel.remote_active) begin
      next_range = sel.remote_range;
    end else if (auto_active && state == ST_TRACK && reading_valid) begin
      if (over_full && range != RANGE_TOP) begin
        next_range = asc_range_e'(range + 3'h1);
      end else if (under_thresh && range != RANGE_BOTTOM) begin
        next_range = asc_range_e'(range - 3'h1);
      end
    end
  end

  always_comb begin
    next_state = state;
    if (next_range != range) begin
      next_state = ST_SETTLE;
    end else if (state == ST_SETTLE && reading_valid && settle_left <= 2'h1) begin
      next_state = ST_TRACK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      range <= RANGE_RST;
      state <= ST_TRACK;
      settle_left <= 2'h0;
    end else begin
      range <= next_range;
      state <= next_state;
      if (next_range != range) begin
        settle_left <= SETTLE_READS;
      end else if (state == ST_SETTLE && reading_valid && settle_left != 2'h0) begin
        settle_left <= settle_left - 2'h1;
      end
    end
  end

  // Display value and top range wrap
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_count <= 11'h000;
      overvolt <= 1'b0;
    end else if (reading_valid) begin
      if (!over_full) begin
        disp_count <= reading_count[10:0];
        overvolt <= 1'b0;
      end else if (range == RANGE_TOP) begin
        overvolt <= 1'b1;
        if (reading_count > CNT_WRAP_MAX) begin
          disp_count <= CNT_WRAP_HOLD[10:0];
        end else begin
          disp_count <= 11'(reading_count - CNT_WRAP_BASE);
        end
      end else begin
        disp_count <= CNT_FULL[10:0];
        overvolt <= 1'b0;
      end
    end
  end

  // Blanking and blinking of the three low digits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_phase <= 1'b0;
    end else if (!overvolt) begin
      blink_phase <= 1'b0;
    end else if (blink_tick) begin
      blink_phase <= !blink_phase;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_digits_on <= 1'b0;
      range_changing <= 1'b0;
      sens_range <= RANGE_RST;
    end else begin
      low_digits_on <= (next_state == ST_TRACK) && !(overvolt && blink_phase);
      range_changing <= (next_state == ST_SETTLE);
      sens_range <= next_range;
    end
  end

  // Function and range checks
  always_comb begin
    bad_range = 1'b0;
    unique case (func)
      FN_VOLT: bad_range = 1'b0;
      FN_OHMS: bad_range = func_range >= OHMS_RANGES;
      FN_COULOMB: bad_range = func_range >= COULOMB_RANGES;
      FN_AMPERE: bad_range = func_range >= AMPERE_RANGES;
    endcase
  end
  // Warn only; resistor heating is the operator's concern
  assign hot_current = func == FN_AMPERE && func_range < AMPERE_HOT_RANGES && range >= RNG_10V;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hot_q <= 1'b0;
      bad_q <= 1'b0;
      overvolt_q <= 1'b0;
    end else begin
      hot_q <= hot_current;
      bad_q <= bad_range;
      overvolt_q <= overvolt;
    end
  end

  always_comb begin
    events = '0;
    events[EV_UP] = next_range > range;
    events[EV_DOWN] = next_range < range;
    events[EV_OVERVOLT] = overvolt && !overvolt_q;
    events[EV_HOT_CURRENT] = hot_current && !hot_q;
    events[EV_BAD_RANGE] = bad_range && !bad_q;
  end

  // Avalon slave: one wait cycle, then the answer
  assign bus_req = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  always_comb begin
    irq_clr = '0;
    if (bus_take && avs_write && avs_address == REG_IRQ_CLR && avs_byteenable[0]) begin
      irq_clr = avs_writedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold <= 1'b0;
      irq_en <= IRQ_EN_RST;
    end else if (bus_take && avs_write && avs_byteenable[0]) begin
      if (avs_address == REG_CTRL) begin
        hold <= avs_writedata[CTRL_HOLD_BIT];
      end
      if (avs_address == REG_IRQ_EN) begin
        irq_en <= avs_writedata[IRQ_W-1:0];
      end
    end
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | events;
      irq <= |(((irq_stat & ~irq_clr) | events) & irq_en);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (bus_req && avs_waitrequest) begin
      unique case (avs_address)
        REG_CTRL: avs_readdata <= {31'h0, hold};
        REG_STATUS: avs_readdata <= {23'h0, bad_range, hot_current, overvolt, state == ST_SETTLE,
                                     sel.remote_active, sel.auto_sel, range};
        REG_IRQ_STAT: avs_readdata <= {27'h0, irq_stat};
        REG_IRQ_EN: avs_readdata <= {27'h0, irq_en};
        REG_READING: avs_readdata <= {21'h0, disp_count};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // Checks
  AST_UPRANGE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    auto_active && state == ST_TRACK && reading_valid && over_full && range != RANGE_TOP
    |=> range == asc_range_e'($past(range) + 3'h1))
    else $error("auto up-range missed");

  AST_DOWNRANGE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    auto_active && state == ST_TRACK && reading_valid && under_thresh && range != RANGE_BOTTOM
    |=> range == asc_range_e'($past(range) - 3'h1))
    else $error("auto down-range missed");

  AST_BLANK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    next_range != range |=> range_changing && !low_digits_on)
    else $error("low digits shown during range change");

  AST_OVERVOLT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reading_valid && range == RANGE_TOP && over_full |=> overvolt)
    else $error("top range overvoltage not flagged");

  AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reading_valid && range == RANGE_TOP && reading_count > CNT_WRAP_MAX
    |=> disp_count == CNT_WRAP_HOLD[10:0])
    else $error("wrap beyond limit not held");

  AST_MANUAL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !sel.auto_sel |=> range == $past(sel.manual_range))
    else $error("manual sensitivity not applied");

  AST_REMOTE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sel.auto_sel && sel.remote_active |=> range == $past(sel.remote_range))
    else $error("remote sensitivity not applied");

  AST_SATURATE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    auto_active && reading_valid && over_full && range == RANGE_TOP
    |=> range == RANGE_TOP)
    else $error("auto ranging stepped past the top");

  AST_FLOOR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    auto_active && reading_valid && under_thresh && range == RANGE_BOTTOM
    |=> range == RANGE_BOTTOM)
    else $error("auto ranging stepped past the bottom");

  AST_BUS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle wide");

  AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    |(events & irq_en) |=> irq)
    else $error("enabled event did not raise interrupt");
endmodule
`default_nettype wire

// ==== verilog/asc_pkg.sv ====
// Purpose: Shared constants and types of the autorange sensitivity controller.
// Assumes: 25 MHz reference clock; counts are display magnitudes in digits.
// Notes: Register offsets are Avalon word addresses.
package asc_pkg;

  // Sensitivity decades, most sensitive first
  typedef enum logic [2:0] {
    RNG_10MV  = 3'h0,
    RNG_100MV = 3'h1,
    RNG_1V    = 3'h2,
    RNG_10V   = 3'h3,
    RNG_100V  = 3'h4
  } asc_range_e;

  typedef enum logic [1:0] {
    FN_VOLT    = 2'h0,
    FN_OHMS    = 2'h1,
    FN_COULOMB = 2'h2,
    FN_AMPERE  = 2'h3
  } asc_func_e;

  typedef enum logic {
    ST_TRACK  = 1'b0,
    ST_SETTLE = 1'b1
  } asc_state_e;

  // Selector position that hands over to auto or remote ranging
  localparam logic [2:0] SEL_AUTO_POS = 3'h5;
  localparam asc_range_e RANGE_TOP = RNG_100V;
  localparam asc_range_e RANGE_BOTTOM = RNG_10MV;
  localparam asc_range_e RANGE_RST = RNG_100V;

  // Display thresholds in counts
  localparam logic [11:0] CNT_DOWN_THRESH = 12'h0B4;
  localparam logic [11:0] CNT_FULL = 12'h7CF;
  localparam logic [11:0] CNT_WRAP_BASE = 12'h7D0;
  localparam logic [11:0] CNT_WRAP_MAX = 12'h7E1;
  localparam logic [11:0] CNT_WRAP_HOLD = 12'h011;

  // Ranges available per function
  localparam logic [3:0] OHMS_RANGES = 4'h8;
  localparam logic [3:0] COULOMB_RANGES = 4'h4;
  localparam logic [3:0] AMPERE_RANGES = 4'hB;
  localparam logic [3:0] AMPERE_HOT_RANGES = 4'h4;

  // Blink timing
  localparam int CLK_HZ = 25000000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam logic [1:0] SETTLE_READS_RST = 2'h1;

  // Register word offsets
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_IRQ_STAT = 3'h2;
  localparam logic [2:0] REG_IRQ_CLR = 3'h3;
  localparam logic [2:0] REG_IRQ_EN = 3'h4;
  localparam logic [2:0] REG_READING = 3'h5;

  // Field positions
  localparam int CTRL_HOLD_BIT = 0;
  localparam int IRQ_W = 5;
  localparam int EV_UP = 0;
  localparam int EV_DOWN = 1;
  localparam int EV_OVERVOLT = 2;
  localparam int EV_HOT_CURRENT = 3;
  localparam int EV_BAD_RANGE = 4;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;

endpackage

// ==== verilog/asc_sel_if.sv ====
// Purpose: Decoded selector and remote programming state.
// Assumes: Driven by the selector decoder, read by the ranging core.
// Notes: All members come from flip-flops in the decoder.
`timescale 1ns/1ns
`default_nettype none
interface asc_sel_if;
  import asc_pkg::*;
  logic auto_sel;
  asc_range_e manual_range;
  logic remote_active;
  asc_range_e remote_range;
  modport src (output auto_sel, output manual_range, output remote_active, output remote_range);
  modport dst (input auto_sel, input manual_range, input remote_active, input remote_range);
endinterface
`default_nettype wire

// ==== verilog/asc_tick.sv ====
// Purpose: One-cycle enable pulse every CYCLES clocks.
// Assumes: CYCLES at least 1.
// Notes: Drives the overvoltage blink phase.
`timescale 1ns/1ns
`default_nettype none
module asc_tick #(
  parameter int CYCLES = 6250000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Pulse
  output logic tick
);
  logic [31:0] count;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count >= 32'(CYCLES - 1)) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/asc_sel_decode.sv ====
// Purpose: Decodes the sensitivity selector and the remote control lines.
// Assumes: Selector and remote lines synchronous to ref_clk.
// Notes: Unlisted remote codes fall back to automatic ranging.
`timescale 1ns/1ns
`default_nettype none
module asc_sel_decode
  import asc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Front selector and remote lines
  input wire logic [2:0] sens_selector,
  input wire logic remote_override_line,
  input wire logic remote_code_weight4,
  input wire logic remote_code_weight2,
  input wire logic remote_code_weight1,
  // Decoded state
  asc_sel_if.src sel
);
  logic next_valid;
  asc_range_e next_remote;

  always_comb begin
    next_valid = 1'b1;
    unique case ({remote_code_weight4, remote_code_weight2, remote_code_weight1})
      3'h0: next_remote = RNG_10MV;
      3'h4: next_remote = RNG_100MV;
      3'h5: next_remote = RNG_1V;
      3'h6: next_remote = RNG_10V;
      3'h7: next_remote = RNG_100V;
      default: begin
        next_remote = RNG_10MV;
        next_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel.auto_sel <= 1'b1;
      sel.manual_range <= RANGE_RST;
      sel.remote_active <= 1'b0;
      sel.remote_range <= RANGE_RST;
    end else begin
      sel.auto_sel <= (sens_selector >= SEL_AUTO_POS);
      // Positions count down from 100 V to 10 mV
      sel.manual_range <= (sens_selector < SEL_AUTO_POS) ? asc_range_e'(3'h4 - sens_selector) : RANGE_RST;
      // Low line overrides; open reads high and returns to auto
      sel.remote_active <= !remote_override_line && next_valid;
      sel.remote_range <= next_remote;
    end
  end

  AST_REMOTE_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    remote_override_line |=> !sel.remote_active)
    else $error("open override line left remote control active");
endmodule
`default_nettype wire

// ==== verification/asc_remote_unit.sv ====
// Purpose: Model of the remote sensitivity programming unit.
// Assumes: Bench sets enable and code just after a clock edge.
// Notes: Released lines read as logic 1, like open lines.
`timescale 1ns/1ns
`default_nettype none
module asc_remote_unit
  import asc_pkg::*;
(
  // Command from bench
  input wire logic enable,
  input wire asc_range_e code,
  // Control lines
  output logic remote_override_line,
  output logic remote_code_weight4,
  output logic remote_code_weight2,
  output logic remote_code_weight1
);
  always_comb begin
    remote_override_line = !enable;
    {remote_code_weight4, remote_code_weight2, remote_code_weight1} = 3'h7;
    if (enable) begin
      case (code)
        RNG_10MV: {remote_code_weight4, remote_code_weight2, remote_code_weight1} = 3'h0;
        RNG_100MV: {remote_code_weight4, remote_code_weight2, remote_code_weight1} = 3'h4;
        RNG_1V: {remote_code_weight4, remote_code_weight2, remote_code_weight1} = 3'h5;
        RNG_10V: {remote_code_weight4, remote_code_weight2, remote_code_weight1} = 3'h6;
        default: {remote_code_weight4, remote_code_weight2, remote_code_weight1} = 3'h7;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the autorange controller.
// Assumes: Blink tick shortened to 8 cycles.
// Notes: Random in-band readings must never move the range.
`timescale 1ns/1ns
`default_nettype none
module tb
  import asc_pkg::*;
;
  logic ref_clk, rst_b, reading_valid, rem_en, avs_read, avs_write, irq, avs_waitrequest;
  logic low_digits_on, overvolt, range_changing, ovl, w4, w2, w1, prev;
  logic [11:0] reading_count;
  logic [2:0] sens_selector, sens_range, avs_address;
  logic [5:0] function_range_selector;
  logic [10:0] disp_count;
  logic [31:0] avs_writedata, avs_readdata, q;
  asc_range_e rem_code;
  int num_errors, total_checks, tog;
  int unsigned seed_val;
  logic [11:0] c;

  asc_remote_unit i_remote (.enable(rem_en), .code(rem_code), .remote_override_line(ovl),
    .remote_code_weight4(w4), .remote_code_weight2(w2), .remote_code_weight1(w1));

  asc_core #(.BLINK_TICK(8)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reading_valid(reading_valid),
    .reading_count(reading_count), .sens_selector(sens_selector),
    .function_range_selector(function_range_selector), .remote_override_line(ovl),
    .remote_code_weight4(w4), .remote_code_weight2(w2), .remote_code_weight1(w1),
    .sens_range(sens_range), .disp_count(disp_count), .low_digits_on(low_digits_on),
    .overvolt(overvolt), .range_changing(range_changing), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) num_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task send(input logic [11:0] cnt);
    @(posedge ref_clk);
    reading_valid <= 1'b1;
    reading_count <= cnt;
    @(posedge ref_clk);
    reading_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task settle_sel;
    repeat (3) @(posedge ref_clk);
  endtask

  task done(input string name);
    $display("test %s finished", name);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    num_errors++;
    complete_run;
  end

  initial begin
    rst_b = 1'b0;
    reading_valid = 1'b0;
    reading_count = 12'h000;
    sens_selector = SEL_AUTO_POS;
    function_range_selector = 6'h00;
    rem_en = 1'b0;
    rem_code = RNG_10MV;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    seed_val = $urandom(32'hBA5F);
    repeat (20) @(posedge ref_clk);
    check(32'(sens_range), 32'(RANGE_RST));
    check(32'(avs_waitrequest), 32'h1);
    rst_b <= 1'b1;
    bus(1'b1, REG_IRQ_EN, 32'h3);
    bus(1'b0, REG_IRQ_EN, 32'h0);
    check(q, 32'h3);
    bus(1'b0, 3'h7, 32'h0);
    check(q, 32'h0);
    done("reset and registers");
    for (int r = 4; r > 0; r--) begin
      send(12'h0B3);
      check(32'(sens_range), r - 1);
      check(32'({range_changing, low_digits_on}), 32'h2);
      send(12'h3E8);
      check(32'({range_changing, low_digits_on}), 32'h1);
    end
    send(12'h000);
    check(32'(sens_range), 32'(RANGE_BOTTOM));
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    check(q, 32'h2);
    check(32'(irq), 32'h1);
    bus(1'b1, REG_IRQ_CLR, 32'h2);
    repeat (2) @(posedge ref_clk);
    check(32'(irq), 32'h0);
    done("down ranging");
    for (int i = 0; i < 22; i++) begin
      c = (i == 0) ? CNT_DOWN_THRESH : (i == 1) ? CNT_FULL : 12'(180 + $urandom_range(1819, 0));
      send(c);
      check(32'(disp_count), 32'(c));
      check(32'(sens_range), 32'(RANGE_BOTTOM));
    end
    done("random in band");
    for (int r = 0; r < 4; r++) begin
      send(12'h7D0);
      check(32'(sens_range), r + 1);
      check(32'({range_changing, low_digits_on, disp_count}), 32'h17CF);
      send(12'h3E8);
    end
    check(32'(irq), 32'h1);
    bus(1'b1, REG_IRQ_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    check(32'(irq), 32'h0);
    done("up ranging");
    send(12'h7D5);
    check(32'({overvolt, disp_count}), 32'h805);
    check(32'(sens_range), 32'(RANGE_TOP));
    tog = 0;
    prev = low_digits_on;
    repeat (40) begin
      @(posedge ref_clk);
      if (low_digits_on !== prev) tog++;
      prev = low_digits_on;
    end
    check(32'(tog >= 3), 32'h1);
    send(12'h834);
    check(32'(disp_count), 32'(CNT_WRAP_HOLD));
    send(12'h7D0);
    check(32'({overvolt, disp_count}), 32'h800);
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'({q[6], q[2:0]}), 32'hC);
    done("top range");
    rem_en <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rem_code <= asc_range_e'(k[2:0]);
      settle_sel;
      check(32'(sens_range), k);
    end
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'(q[4]), 32'h1);
    sens_selector <= 3'h2;
    settle_sel;
    check(32'(sens_range), 32'(RNG_1V));
    done("remote");
    for (int s = 0; s < 5; s++) begin
      sens_selector <= 3'(s);
      settle_sel;
      check(32'(sens_range), 4 - s);
    end
    sens_selector <= 3'h1;
    function_range_selector <= 6'h30;
    settle_sel;
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'(q[8:7]), 32'h1);
    function_range_selector <= 6'h18;
    settle_sel;
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'(q[8:7]), 32'h2);
    function_range_selector <= 6'h17;
    settle_sel;
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'(q[8:7]), 32'h0);
    done("selectors");
    rem_en <= 1'b0;
    sens_selector <= SEL_AUTO_POS;
    settle_sel;
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'(q[4:3]), 32'h1);
    // End the pending change so only hold can block ranging
    send(12'h3E8);
    bus(1'b1, REG_CTRL, 32'h1);
    send(12'h0B3);
    check(32'(sens_range), 32'(RNG_10V));
    bus(1'b1, REG_CTRL, 32'h0);
    send(12'h0B3);
    check(32'(sens_range), 32'(RNG_1V));
    done("override release and hold");
    complete_run;
  end
endmodule
`default_nettype wire
